// [core/ufsc_pkg.sv]
package ufsc_pkg;
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_STA = 8'h04;
  localparam logic [7:0] OFS_TXD = 8'h08;
  localparam logic [7:0] OFS_RXD = 8'h0C;
  localparam logic [7:0] OFS_BRG = 8'h10;
  localparam logic [31:0] MODE_WMASK = 32'h0000903F;
  localparam logic [31:0] STA_WMASK = 32'hFFFFFCE0;
  localparam logic [31:0] REG_RST = 32'h00000000;
  localparam logic [15:0] BRG_RST = 16'h0019;
  localparam int P_ON = 15;
  localparam int P_IR = 12;
  localparam int P_ARM = 5;
  localparam int P_RXPOL = 4;
  localparam int P_FAST = 3;
  localparam int P_FMT = 1;
  localparam int P_STOP = 0;
  localparam int P_MASK = 24;
  localparam int P_ADR = 16;
  localparam int P_TXLVL = 14;
  localparam int P_TXPOL = 13;
  localparam int P_RXON = 12;
  localparam int P_BRK = 11;
  localparam int P_TXON = 10;
  localparam int P_TXFULL = 9;
  localparam int P_TXIDLE = 8;
  localparam int P_RXLVL = 6;
  localparam int P_ADET = 5;
  localparam int P_RXIDLE = 4;
  localparam int P_PAR = 3;
  localparam int P_FRM = 2;
  localparam int P_OVR = 1;
  localparam int P_HAS = 0;
  typedef enum logic [1:0] {
    FMT_8N = 2'h0,
    FMT_8E = 2'h1,
    FMT_8O = 2'h2,
    FMT_9N = 2'h3
  } ufsc_fmt_t;
  localparam logic [1:0] LVL_ANY = 2'h0;
  localparam logic [1:0] LVL_MID = 2'h1;
  localparam logic [1:0] LVL_HI = 2'h2;
  localparam int OVS_FAST = 4;
  localparam int OVS_STD = 16;
  localparam logic [3:0] DATA8 = 4'h8;
  localparam logic [3:0] FRAME8 = 4'hA;
  localparam logic [3:0] BRK_BITS = 4'hE;
  localparam int AB_SHIFT_FAST = 5;
  localparam int AB_SHIFT_STD = 7;
  localparam logic [2:0] AB_EDGES = 3'h4;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
endpackage

// [core/ufsc_tx_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface ufsc_tx_if;
  logic tick;
  logic fast;
  logic on;
  logic stop2;
  logic irOn;
  logic pol;
  logic brk;
  logic brkDone;
  logic vld;
  logic rdy;
  logic busy;
  logic pin;
  ufsc_pkg::ufsc_fmt_t fmt;
  logic [8:0] data;
  modport core (
    output tick, fast, on, stop2, irOn, pol, brk, vld, data, fmt,
    input brkDone, rdy, busy, pin
  );
  modport shifter (
    input tick, fast, on, stop2, irOn, pol, brk, vld, data, fmt,
    output brkDone, rdy, busy, pin
  );
endinterface
`default_nettype wire

// [core/ufsc_tx.sv]
`timescale 1ns/1ps
`default_nettype none
module ufsc_tx (
  input wire logic clk_sys,
  input wire logic rst_n,
  ufsc_tx_if.shifter tx
);
  import ufsc_pkg::*;
  logic [13:0] sh_r;
  logic [3:0] left_r;
  logic [3:0] ph_r;
  logic busy_r;
  logic brk_r;
  logic done_r;
  logic pin_r;
  logic [3:0] bitLast;
  logic [3:0] irLast;
  logic [3:0] len;
  logic [13:0] frame;
  logic par;
  logic lineBit;
  logic irPulse;

  always_comb begin
    bitLast = tx.fast ? 4'(OVS_FAST - 1) : 4'(OVS_STD - 1);
    irLast = tx.fast ? 4'(OVS_FAST / 4) : 4'(OVS_STD / 4);
    par = (^tx.data[7:0]) ^ (tx.fmt == FMT_8O);
    case (tx.fmt)
      FMT_9N: frame = {4'hF, tx.data, 1'b0};
      FMT_8E, FMT_8O: frame = {4'hF, par, tx.data[7:0], 1'b0};
      default: frame = {5'h1F, tx.data[7:0], 1'b0};
    endcase
    len = ((tx.fmt == FMT_8N) ? FRAME8 : FRAME8 + 4'h1) + 4'(tx.stop2);
    lineBit = (tx.on && busy_r) ? sh_r[0] : 1'b1;
    irPulse = !lineBit && (ph_r < irLast);
  end

  // a pending break holds off new data so the break frame goes first
  assign tx.rdy = tx.on && !busy_r && !tx.brk;
  assign tx.busy = busy_r;
  assign tx.brkDone = done_r;
  assign tx.pin = pin_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sh_r <= 14'h3FFF;
      left_r <= 4'h0;
      ph_r <= 4'h0;
      busy_r <= 1'b0;
      brk_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (!tx.on) begin
        busy_r <= 1'b0;
      end else if (!busy_r) begin
        ph_r <= 4'h0;
        // the request bit falls a cycle after the break ends; done_r stops a repeat
        if (tx.brk && !done_r) begin
          sh_r <= {1'b1, 13'h0000};
          left_r <= BRK_BITS;
          brk_r <= 1'b1;
          busy_r <= 1'b1;
        end else if (tx.vld && tx.rdy) begin
          sh_r <= frame;
          left_r <= len;
          brk_r <= 1'b0;
          busy_r <= 1'b1;
        end
      end else if (tx.tick) begin
        if (ph_r == bitLast) begin
          ph_r <= 4'h0;
          sh_r <= {1'b1, sh_r[13:1]};
          left_r <= left_r - 4'h1;
          if (left_r == 4'h1) begin
            busy_r <= 1'b0;
            done_r <= brk_r;
          end
        end else begin
          ph_r <= ph_r + 4'h1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_r <= 1'b1;
    end else if (tx.irOn) begin
      pin_r <= irPulse ^ tx.pol;
    end else begin
      pin_r <= lineBit ^ tx.pol;
    end
  end
endmodule
`default_nettype wire

// [core/ufsc_top.sv]
// Notes on behaviour
// - armed auto-rate measures sync char, then disarms
// - receive polarity bit picks idle level
// - oversample four times fast, sixteen standard
// - format field picks data bits and parity
// - stop count bit gives one or two
// - mask byte selects compared address bits
// - address byte is the match value
// - transmit level code picks flag condition
// - plain line idles low when inverted
// - encoded line idles high when inverted
// - receiver off ignores input pin
// - break sends start, twelve zeros, stop
// - transmitter off aborts and empties buffer
// - full flag shows transmit buffer full
// - idle flag needs shifter and buffer empty
// - receive level code picks flag condition
// - overrun sticky, clearing empties receive path
// - address mode only with nine-bit format
//
// Implementation choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module ufsc_top #(
  parameter int RX_DEPTH = 4,
  parameter int TX_DEPTH = 4
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic serialInPin,
  output logic serialOutPin,
  output logic serialOutEn,
  output logic txLevelHit,
  output logic rxLevelHit
);
  import ufsc_pkg::*;
  localparam int RXA = $clog2(RX_DEPTH);
  localparam int TXA = $clog2(TX_DEPTH);
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_BITS, RX_STOP, RX_SYNC} ufsc_rxst_t;

  function automatic logic [31:0] mergeStrb(input logic [31:0] o, input logic [31:0] n,
                                            input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) r[i*8 +: 8] = n[i*8 +: 8];
    end
    return r;
  endfunction

  function automatic int bump(input int p, input int d);
    return (p == d - 1) ? 0 : p + 1;
  endfunction

  ufsc_tx_if tx ();
  logic [31:0] mode_r;
  logic [31:0] ctl_r;
  logic [15:0] brg_r;
  logic [15:0] brgCnt_r;
  logic tick_r;
  logic overrun_fault_flag_r;
  logic awRdy_r, wRdy_r, awHeld_r, wHeld_r, bVld_r, arRdy_r, rVld_r;
  logic [1:0] bResp_r, rResp_r;
  logic [7:0] awAdr_r;
  logic [31:0] wDat_r, rDat_r;
  logic [3:0] wStb_r;
  logic txLvl_r, rxLvl_r, outEn_r;
  ufsc_rxst_t rxSt_r;
  logic [3:0] rxPh_r, rxIdx_r;
  logic [8:0] rxSh_r;
  logic lineQ_r, rxPush_r, acc_r, abDone_r;
  logic [10:0] rxWord_r;
  logic [23:0] abCnt_r;
  logic [2:0] abEdge_r;
  logic [15:0] abBrg_r;
  logic [10:0] rxMem_r [RX_DEPTH];
  logic [RXA-1:0] rxWr_r, rxRd_r;
  logic [RXA:0] rxCnt_r;
  logic [8:0] txMem_r [TX_DEPTH];
  logic [TXA-1:0] txWr_r, txRd_r;
  logic [TXA:0] txCnt_r;

  ufsc_fmt_t fmt;
  logic on, fast, rxOn, txOn, adet, line;
  logic doWr, wMode, wSta, wTxd, wBrg, wHit, arHs, rxPop, rxFull, rxFlush, oerrClr;
  logic txPush, txPop, txFull, txIdle, rdHit;
  logic [31:0] staRd, staW, rdv;
  logic [10:0] rxHead;
  logic [3:0] bitLast, halfLast, nBits;
  logic [8:0] dOut;
  logic [23:0] abq;
  logic parity_fault_flag, isAdr, match;

  assign fmt = ufsc_fmt_t'(mode_r[P_FMT +: 2]);
  assign on = mode_r[P_ON];
  assign fast = mode_r[P_FAST];
  assign rxOn = on && ctl_r[P_RXON];
  assign txOn = on && ctl_r[P_TXON];
  assign adet = ctl_r[P_ADET] && (fmt == FMT_9N);
  assign line = rxOn ? (serialInPin ^ mode_r[P_RXPOL]) : 1'b1;

  assign doWr = awHeld_r && wHeld_r && !bVld_r;
  assign wMode = doWr && (awAdr_r == OFS_MODE);
  assign wSta = doWr && (awAdr_r == OFS_STA);
  assign wTxd = doWr && (awAdr_r == OFS_TXD);
  assign wBrg = doWr && (awAdr_r == OFS_BRG);
  assign wHit = wMode || wSta || wTxd || wBrg || (awAdr_r == OFS_RXD);
  assign arHs = s_axi_arvalid && arRdy_r;
  assign rxPop = arHs && (s_axi_araddr == OFS_RXD) && (rxCnt_r != '0);
  assign rxFull = (int'(rxCnt_r) == RX_DEPTH);
  assign staW = mergeStrb(staRd, wDat_r, wStb_r);
  assign oerrClr = wSta && overrun_fault_flag_r && !staW[P_OVR];
  // a new overrun in the same cycle keeps the flag and the buffer contents
  assign rxFlush = oerrClr && !(rxPush_r && rxFull);
  assign txFull = (int'(txCnt_r) == TX_DEPTH);
  assign txIdle = (txCnt_r == '0) && !tx.busy;
  assign txPush = wTxd && ctl_r[P_TXON] && !txFull;
  assign txPop = tx.vld && tx.rdy;
  assign rxHead = rxMem_r[rxRd_r];

  always_comb begin
    staRd = ctl_r;
    staRd[P_TXFULL] = txFull;
    staRd[P_TXIDLE] = txIdle;
    staRd[P_RXIDLE] = (rxSt_r == RX_IDLE);
    staRd[P_PAR] = (rxCnt_r != '0) && rxHead[9];
    staRd[P_FRM] = (rxCnt_r != '0) && rxHead[10];
    staRd[P_OVR] = overrun_fault_flag_r;
    staRd[P_HAS] = (rxCnt_r != '0);
    rdHit = 1'b1;
    case (s_axi_araddr)
      OFS_MODE: rdv = mode_r;
      OFS_STA: rdv = staRd;
      OFS_TXD: rdv = REG_RST;
      OFS_RXD: rdv = {23'h000000, rxHead[8:0]};
      OFS_BRG: rdv = {16'h0000, brg_r};
      default: begin
        rdv = REG_RST;
        rdHit = 1'b0;
      end
    endcase
  end

  assign s_axi_awready = awRdy_r;
  assign s_axi_wready = wRdy_r;
  assign s_axi_bvalid = bVld_r;
  assign s_axi_bresp = bResp_r;
  assign s_axi_arready = arRdy_r;
  assign s_axi_rvalid = rVld_r;
  assign s_axi_rdata = rDat_r;
  assign s_axi_rresp = rResp_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      awRdy_r <= 1'b1;
      wRdy_r <= 1'b1;
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      bVld_r <= 1'b0;
      bResp_r <= RESP_OK;
      awAdr_r <= 8'h00;
      wDat_r <= REG_RST;
      wStb_r <= 4'h0;
    end else begin
      if (s_axi_awvalid && awRdy_r) begin
        awHeld_r <= 1'b1;
        awAdr_r <= s_axi_awaddr;
        awRdy_r <= 1'b0;
      end
      if (s_axi_wvalid && wRdy_r) begin
        wHeld_r <= 1'b1;
        wDat_r <= s_axi_wdata;
        wStb_r <= s_axi_wstrb;
        wRdy_r <= 1'b0;
      end
      if (doWr) begin
        awHeld_r <= 1'b0;
        wHeld_r <= 1'b0;
        bVld_r <= 1'b1;
        bResp_r <= wHit ? RESP_OK : RESP_ERR;
      end
      if (bVld_r && s_axi_bready) begin
        bVld_r <= 1'b0;
        awRdy_r <= 1'b1;
        wRdy_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      arRdy_r <= 1'b1;
      rVld_r <= 1'b0;
      rDat_r <= REG_RST;
      rResp_r <= RESP_OK;
    end else if (arHs) begin
      arRdy_r <= 1'b0;
      rVld_r <= 1'b1;
      rDat_r <= rdv;
      rResp_r <= rdHit ? RESP_OK : RESP_ERR;
    end else if (rVld_r && s_axi_rready) begin
      rVld_r <= 1'b0;
      arRdy_r <= 1'b1;
    end
  end

  // software writes win over the hardware clears of arm and break
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mode_r <= REG_RST;
      ctl_r <= REG_RST;
      brg_r <= BRG_RST;
    end else begin
      if (wMode) begin
        mode_r <= mergeStrb(mode_r, wDat_r, wStb_r) & MODE_WMASK;
      end else if (abDone_r) begin
        mode_r[P_ARM] <= 1'b0;
      end
      if (wSta) begin
        ctl_r <= staW & STA_WMASK;
      end else if (tx.brkDone) begin
        ctl_r[P_BRK] <= 1'b0;
      end
      if (wBrg) begin
        brg_r <= 16'(mergeStrb({16'h0000, brg_r}, wDat_r, wStb_r));
      end else if (abDone_r) begin
        brg_r <= abBrg_r;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      overrun_fault_flag_r <= 1'b0;
    end else if (rxPush_r && rxFull) begin
      overrun_fault_flag_r <= 1'b1;
    end else if (oerrClr) begin
      overrun_fault_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      brgCnt_r <= 16'h0000;
      tick_r <= 1'b0;
    end else if (!on || brgCnt_r == brg_r) begin
      brgCnt_r <= 16'h0000;
      tick_r <= on;
    end else begin
      brgCnt_r <= brgCnt_r + 16'h0001;
      tick_r <= 1'b0;
    end
  end

  always_comb begin
    bitLast = fast ? 4'(OVS_FAST - 1) : 4'(OVS_STD - 1);
    halfLast = fast ? 4'(OVS_FAST / 2 - 1) : 4'(OVS_STD / 2 - 1);
    nBits = (fmt == FMT_8N) ? DATA8 : DATA8 + 4'h1;
    case (fmt)
      FMT_9N: dOut = rxSh_r;
      FMT_8N: dOut = {1'b0, rxSh_r[8:1]};
      default: dOut = {1'b0, rxSh_r[7:0]};
    endcase
    parity_fault_flag = (fmt inside {FMT_8E, FMT_8O}) && ((^rxSh_r) ^ (fmt == FMT_8O));
    isAdr = adet && dOut[8];
    match = ((dOut[7:0] ^ ctl_r[P_ADR +: 8]) & ctl_r[P_MASK +: 8]) == 8'h00;
    abq = abCnt_r >> (fast ? AB_SHIFT_FAST : AB_SHIFT_STD);
  end

  // only the first stop bit is checked; a second one just reads as idle line
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rxSt_r <= RX_IDLE;
      rxPh_r <= 4'h0;
      rxIdx_r <= 4'h0;
      rxSh_r <= 9'h000;
      lineQ_r <= 1'b1;
      rxPush_r <= 1'b0;
      rxWord_r <= 11'h000;
      acc_r <= 1'b0;
      abCnt_r <= 24'h000000;
      abEdge_r <= 3'h0;
      abDone_r <= 1'b0;
      abBrg_r <= BRG_RST;
    end else begin
      rxPush_r <= 1'b0;
      abDone_r <= 1'b0;
      lineQ_r <= line;
      if (!rxOn || rxFlush) begin
        rxSt_r <= RX_IDLE;
      end else begin
        case (rxSt_r)
          RX_IDLE: if (!line) begin
            rxPh_r <= 4'h0;
            rxIdx_r <= 4'h0;
            abCnt_r <= 24'h000000;
            abEdge_r <= 3'h0;
            rxSt_r <= mode_r[P_ARM] ? RX_SYNC : RX_START;
          end
          RX_START: if (tick_r) begin
            if (rxPh_r == halfLast) begin
              rxPh_r <= 4'h0;
              rxSt_r <= line ? RX_IDLE : RX_BITS;
            end else begin
              rxPh_r <= rxPh_r + 4'h1;
            end
          end
          RX_BITS: if (tick_r) begin
            if (rxPh_r == bitLast) begin
              rxPh_r <= 4'h0;
              rxSh_r <= {line, rxSh_r[8:1]};
              rxIdx_r <= rxIdx_r + 4'h1;
              if (rxIdx_r == nBits - 4'h1) rxSt_r <= RX_STOP;
            end else begin
              rxPh_r <= rxPh_r + 4'h1;
            end
          end
          RX_STOP: if (tick_r) begin
            if (rxPh_r == bitLast) begin
              rxSt_r <= RX_IDLE;
              rxWord_r <= {!line, parity_fault_flag, dOut};
              if (isAdr) begin
                acc_r <= match;
                rxPush_r <= match;
              end else begin
                rxPush_r <= !adet || acc_r;
              end
            end else begin
              rxPh_r <= rxPh_r + 4'h1;
            end
          end
          RX_SYNC: begin
            // counting stops at the fourth falling edge, eight bit times after the start
            if (abEdge_r != AB_EDGES) begin
              abCnt_r <= abCnt_r + 24'h000001;
              if (lineQ_r && !line) abEdge_r <= abEdge_r + 3'h1;
            end
            if (line && !lineQ_r && abEdge_r == AB_EDGES) begin
              abDone_r <= 1'b1;
              abBrg_r <= abq[15:0] - 16'h0001;
              rxSt_r <= RX_IDLE;
            end
          end
          default: rxSt_r <= RX_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rxPush_r && !rxFull) rxMem_r[rxWr_r] <= rxWord_r;
    if (txPush) txMem_r[txWr_r] <= wDat_r[8:0];
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rxWr_r <= '0;
      rxRd_r <= '0;
      rxCnt_r <= '0;
    end else if (rxFlush) begin
      rxWr_r <= '0;
      rxRd_r <= '0;
      rxCnt_r <= '0;
    end else begin
      if (rxPush_r && !rxFull) rxWr_r <= RXA'(bump(int'(rxWr_r), RX_DEPTH));
      if (rxPop) rxRd_r <= RXA'(bump(int'(rxRd_r), RX_DEPTH));
      rxCnt_r <= rxCnt_r + (RXA+1)'(rxPush_r && !rxFull) - (RXA+1)'(rxPop);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      txWr_r <= '0;
      txRd_r <= '0;
      txCnt_r <= '0;
    end else if (!ctl_r[P_TXON]) begin
      txWr_r <= '0;
      txRd_r <= '0;
      txCnt_r <= '0;
    end else begin
      if (txPush) txWr_r <= TXA'(bump(int'(txWr_r), TX_DEPTH));
      if (txPop) txRd_r <= TXA'(bump(int'(txRd_r), TX_DEPTH));
      txCnt_r <= txCnt_r + (TXA+1)'(txPush) - (TXA+1)'(txPop);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      txLvl_r <= 1'b0;
      rxLvl_r <= 1'b0;
      outEn_r <= 1'b0;
    end else begin
      outEn_r <= txOn;
      case (ctl_r[P_TXLVL +: 2])
        LVL_HI: txLvl_r <= (txCnt_r == '0);
        LVL_MID: txLvl_r <= txIdle;
        LVL_ANY: txLvl_r <= !txFull;
        default: txLvl_r <= 1'b0;
      endcase
      case (ctl_r[P_RXLVL +: 2])
        LVL_HI: rxLvl_r <= int'(rxCnt_r) * 4 >= RX_DEPTH * 3;
        LVL_MID: rxLvl_r <= int'(rxCnt_r) * 2 >= RX_DEPTH;
        LVL_ANY: rxLvl_r <= (rxCnt_r != '0);
        default: rxLvl_r <= 1'b0;
      endcase
    end
  end

  assign tx.tick = tick_r;
  assign tx.fast = fast;
  assign tx.on = txOn;
  assign tx.stop2 = mode_r[P_STOP];
  assign tx.irOn = mode_r[P_IR];
  assign tx.pol = ctl_r[P_TXPOL];
  assign tx.brk = ctl_r[P_BRK];
  assign tx.fmt = fmt;
  assign tx.vld = (txCnt_r != '0);
  assign tx.data = txMem_r[txRd_r];
  assign serialOutPin = tx.pin;
  assign serialOutEn = outEn_r;
  assign txLevelHit = txLvl_r;
  assign rxLevelHit = rxLvl_r;

  ufsc_tx u_tx (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .tx(tx)
  );
endmodule
`default_nettype wire

// [verification/ufsc_peer.sv]
`timescale 1ns/1ps
`default_nettype none
module ufsc_peer (
  input wire logic clk_sys,
  input wire logic txLine,
  output logic rxLine
);
  int bitLen = 4;
  initial rxLine = 1'b1;
  // one idle cycle ahead of each frame, so back-to-back sends never collide
  task automatic send(input logic [13:0] b, input int n, input logic inv);
    @(posedge clk_sys);
    for (int i = 0; i < n; i++) begin
      rxLine <= b[i] ^ inv;
      repeat (bitLen) @(posedge clk_sys);
    end
    rxLine <= ~inv;
  endtask
  task automatic grab(input int n, output logic [13:0] b);
    b = '1;
    @(posedge clk_sys);
    while (txLine !== 1'b0) @(posedge clk_sys);
    repeat (bitLen / 2) @(posedge clk_sys);
    for (int i = 0; i < n; i++) begin
      b[i] = txLine;
      repeat (bitLen) @(posedge clk_sys);
    end
  endtask
endmodule
`default_nettype wire

// [verification/ufsc_top_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module ufsc_top_assertions #(
  parameter int RX_DEPTH = 4,
  parameter int TX_DEPTH = 4
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic serialOutPin,
  input wire logic serialOutEn
);
  import ufsc_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_wr;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_bans;
    s_wr |-> ##[1:3] s_axi_bvalid;
  endproperty
  a_bans: assert property (p_bans) else $error("write not answered");
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  property p_bblk;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_bblk: assert property (p_bblk) else $error("write taken during response");
  property p_rans;
    s_rd |-> ##[1:2] s_axi_rvalid;
  endproperty
  a_rans: assert property (p_rans) else $error("read not answered");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped");
  property p_rblk;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_rblk: assert property (p_rblk) else $error("read taken during response");
  property p_rerr;
    s_rd and s_axi_araddr > 8'h10 |-> ##[1:2] s_axi_rvalid && s_axi_rresp == RESP_ERR
      && s_axi_rdata == 32'h0;
  endproperty
  a_rerr: assert property (p_rerr) else $error("unmapped read accepted");
  property p_werr;
    s_wr and s_axi_awaddr > 8'h10 |-> ##[1:3] s_axi_bvalid && s_axi_bresp == RESP_ERR;
  endproperty
  a_werr: assert property (p_werr) else $error("unmapped write accepted");
  property p_rstline;
    $rose(rst_n) |-> serialOutPin && !serialOutEn;
  endproperty
  a_rstline: assert property (p_rstline) else $error("line not idle after reset");
endmodule
bind ufsc_top ufsc_top_assertions #(.RX_DEPTH(RX_DEPTH), .TX_DEPTH(TX_DEPTH)) u_chk (.*);
`default_nettype wire

// [verification/uart_frame_and_status_control_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module uart_frame_and_status_control_tb;
  import ufsc_pkg::*;
  logic clk_sys, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic serialInPin, serialOutPin, serialOutEn, txLevelHit, rxLevelHit;
  logic [13:0] fBits, got;
  logic [8:0] adrSeq [5] = '{9'h011, 9'h1A0, 9'h033, 9'h15A, 9'h022};
  int fLen, errTotal, nCompared, cyc;
  ufsc_top #(.RX_DEPTH(4), .TX_DEPTH(4)) u_dut (.clk_sys, .rst_n, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .serialInPin, .serialOutPin,
    .serialOutEn, .txLevelHit, .rxLevelHit);
  ufsc_peer u_peer (.clk_sys, .txLine(serialOutPin), .rxLine(serialInPin));
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errTotal++;
      giveVerdict();
    end
  end
  task giveVerdict();
    $display("compares %0d errors %0d", nCompared, errTotal);
    if (errTotal == 0 && nCompared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    nCompared++;
    if (g !== e) begin
      errTotal++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OK);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge clk_sys);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(er));
  endtask
  task rd(input logic [7:0] a, input logic [1:0] er = RESP_OK);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge clk_sys);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    rv = s_axi_rdata;
    chk(32'(s_axi_rresp), 32'(er));
  endtask
  task mkf(input logic [8:0] d, input int f, input int s);
    int k;
    fBits = '1;
    fBits[0] = 1'b0;
    k = (f == 3) ? 9 : 8;
    for (int i = 0; i < k; i++) fBits[i + 1] = d[i];
    k++;
    if (f == 1 || f == 2) begin
      fBits[k] = ^d[7:0] ^ (f == 2);
      k++;
    end
    fLen = k + 1 + s;
  endtask
  initial begin
    {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    {errTotal, nCompared, cyc} = '0;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(OFS_STA);
    chk(rv, 32'h00000110);
    rd(8'h14, RESP_ERR);
    chk(rv, 32'h0);
    wr(8'h14, 32'hFFFFFFFF, RESP_ERR);
    wr(OFS_BRG, 32'h0);
    wr(OFS_STA, 32'h1400);
    // last pass runs standard oversampling, the rest fast
    for (int i = 0; i < 8; i++) begin
      u_peer.bitLen = (i < 7) ? 4 : 16;
      wr(OFS_MODE, 32'h8000 | ((i < 7) ? 8 : 0) | i);
      mkf(9'h1A5, i >> 1, i & 1);
      fork
        u_peer.grab(fLen, got);
        wr(OFS_TXD, 32'h1A5);
      join
      chk(32'(got), 32'(fBits));
      u_peer.send(fBits, fLen, 1'b0);
      rd(OFS_STA);
      chk(32'(rv[3:0]), 32'h1);
      rd(OFS_RXD);
      chk(32'(rv[8:0]), (i > 5) ? 32'h1A5 : 32'h0A5);
    end
    u_peer.bitLen = 4;
    wr(OFS_MODE, 32'h800A);
    mkf(9'h0C3, 1, 0);
    fBits[9] = ~fBits[9];
    u_peer.send(fBits, fLen, 1'b0);
    rd(OFS_STA);
    chk(32'(rv[3:0]), 32'h9);
    rd(OFS_RXD);
    rd(OFS_STA);
    chk(32'(rv[3:0]), 32'h0);
    // receiver off while the line flips, so the flip cannot look like a start bit
    wr(OFS_STA, 32'h0400);
    u_peer.send(14'h0, 0, 1'b1);
    wr(OFS_MODE, 32'h8018);
    wr(OFS_STA, 32'h1400);
    mkf(9'h03C, 0, 0);
    u_peer.send(fBits, fLen, 1'b1);
    rd(OFS_RXD);
    chk(32'(rv[8:0]), 32'h03C);
    rd(OFS_STA);
    chk(32'(rv[0]), 32'h0);
    wr(OFS_STA, 32'h0400);
    u_peer.send(14'h0, 0, 1'b0);
    wr(OFS_MODE, 32'h8008);
    wr(OFS_STA, 32'h2400);
    repeat (4) @(posedge clk_sys);
    chk(32'(serialOutPin), 32'h0);
    chk(32'(serialOutEn), 32'h1);
    wr(OFS_MODE, 32'h9008);
    repeat (4) @(posedge clk_sys);
    chk(32'(serialOutPin), 32'h1);
    wr(OFS_MODE, 32'h8008);
    wr(OFS_STA, 32'h1400);
    repeat (6) wr(OFS_TXD, 32'h55);
    rd(OFS_STA);
    chk(32'(rv[9:8]), 32'h2);
    chk(32'(txLevelHit), 32'h0);
    wr(OFS_STA, 32'h1000);
    rd(OFS_STA);
    chk(32'(rv[9:8]), 32'h1);
    for (int c = 0; c < 4; c++) begin
      wr(OFS_STA, 32'h1400 | (c << 14));
      repeat (2) @(posedge clk_sys);
      chk(32'(txLevelHit), 32'(c != 3));
    end
    repeat (60) @(posedge clk_sys);
    fork
      u_peer.grab(14, got);
      wr(OFS_STA, 32'h1C00);
    join
    chk(32'(got), 32'h2000);
    repeat (8) @(posedge clk_sys);
    chk(32'(serialOutPin), 32'h1);
    rd(OFS_STA);
    chk(32'(rv[11]), 32'h0);
    wr(OFS_STA, 32'h1440);
    mkf(9'h011, 0, 0);
    repeat (5) u_peer.send(fBits, fLen, 1'b0);
    chk(32'(rxLevelHit), 32'h1);
    rd(OFS_STA);
    chk(32'(rv[1:0]), 32'h3);
    wr(OFS_STA, 32'h1440);
    rd(OFS_STA);
    chk(32'(rv[1:0]), 32'h0);
    wr(OFS_MODE, 32'h800E);
    wr(OFS_STA, 32'hF0501420);
    for (int i = 0; i < 5; i++) begin
      mkf(adrSeq[i], 3, 0);
      u_peer.send(fBits, fLen, 1'b0);
    end
    rd(OFS_RXD);
    chk(32'(rv[8:0]), 32'h15A);
    rd(OFS_RXD);
    chk(32'(rv[8:0]), 32'h022);
    rd(OFS_STA);
    chk(32'(rv[0]), 32'h0);
    wr(OFS_MODE, 32'h8028);
    mkf(9'h055, 0, 0);
    u_peer.bitLen = 32;
    u_peer.send(fBits, fLen, 1'b0);
    rd(OFS_MODE);
    chk(32'(rv[5]), 32'h0);
    rd(OFS_BRG);
    chk(rv, 32'h7);
    giveVerdict();
  end
endmodule
`default_nettype wire
